/* File: sim/adc_port_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module adc_port_checker
    import adc_port_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              sys_rst,
    input wire logic              chip_sel_n,
    input wire logic              write_n,
    input wire logic              read_n,
    input wire logic [DATA_W-1:0] host_data_bus_in,
    input wire logic              host_data_bus_oe,
    input wire logic              power_down,
    input wire logic              busy_int_n
);
    logic mode_q;
    logic pd_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Shadow of the control bits seen on selected writes
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_q <= 1'b0;
            pd_q <= 1'b0;
        end else if (!chip_sel_n && !write_n) begin
            mode_q <= host_data_bus_in[FLAG_MODE_POS];
            pd_q <= host_data_bus_in[POWER_DOWN_POS];
        end
    end
    chk_sel_bus_off: assert property (
        chip_sel_n[*6] |-> !host_data_bus_oe)
        else $error("bus driven while deselected");
    chk_read_drives: assert property (
        (!chip_sel_n && !read_n)[*6] |-> host_data_bus_oe)
        else $error("read not answered");
    chk_read_release: assert property (
        $rose(read_n) |-> ##[1:6] !host_data_bus_oe)
        else $error("bus held after read");
    chk_int_clear: assert property (
        mode_q && !busy_int_n && !chip_sel_n && $fell(read_n)
        |-> ##[1:6] busy_int_n) else $error("flag not cleared");
    chk_int_hold: assert property (
        (mode_q && read_n && write_n && !busy_int_n)[*6] |=> !busy_int_n)
        else $error("flag dropped without strobe");
    chk_busy_min: assert property (
        !mode_q && $fell(busy_int_n) |-> !busy_int_n[*8])
        else $error("busy too short");
    chk_busy_max: assert property (
        !mode_q && $fell(busy_int_n) |-> ##[14:40] busy_int_n)
        else $error("busy never ends");
    chk_pd_follow: assert property (
        write_n[*8] |-> power_down == pd_q)
        else $error("power down bit not latched");
    cover property ($fell(busy_int_n) && mode_q);
    cover property ($fell(busy_int_n) && !mode_q);
    cover property ($rose(host_data_bus_oe));
endmodule
bind adc_parallel_host_port adc_port_checker i_chk (.ref_clk, .sys_rst,
    .chip_sel_n, .write_n, .read_n, .host_data_bus_in, .host_data_bus_oe,
    .power_down, .busy_int_n);
`default_nettype wire

/* File: sim/host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module host_model
    import adc_port_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic [DATA_W-1:0] dev_out,
    input  wire logic              dev_oe,
    output logic                   cs_n,
    output logic                   wr_n,
    output logic                   rd_n,
    output logic [DATA_W-1:0]      bus
);
    logic [DATA_W-1:0] d = '0;
    logic              drv = 1'b0;
    initial cs_n = 1'b1;
    initial wr_n = 1'b1;
    initial rd_n = 1'b1;
    // Released bus shows the inverse of the last host value
    assign bus = dev_oe ? dev_out : (drv ? d : ~d);
    task automatic wr(input logic [DATA_W-1:0] v, input logic sel_n);
        #1;
        cs_n = sel_n;
        d = v;
        drv = 1'b1;
        wr_n = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1 wr_n = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 cs_n = 1'b1;
        drv = 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask
    task automatic rd(output logic [DATA_W-1:0] v);
        #1 cs_n = 1'b0;
        rd_n = 1'b0;
        repeat (8) @(posedge ref_clk);
        v = bus;
        #1 cs_n = 1'b1;
        rd_n = 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import adc_port_pkg::*;
    typedef struct packed {
        logic [9:0] ctrl;
        logic [9:0] e1;
        logic [9:0] e2;
    } row_s;
    logic                       ref_clk = 1'b0;
    logic                       sys_rst = 1'b1;
    logic                       cs_n, wr_n, rd_n, oe, pd, busy_int_n;
    logic [DATA_W-1:0]          bus, dout;
    logic [NUM_CHAN*DATA_W-1:0] analog_codes;
    logic [CHAN_W-1:0]          chan;
    logic                       hold;
    int                         error_cnt = 0;
    int                         checked = 0;
    function automatic logic [9:0] code(int k);
        return 10'(10'h013 * (k + 1));
    endfunction
    row_s rows [0:4] = '{'{10'h005, code(5), 10'h000},
        '{10'h04A, code(2), code(1)}, '{10'h207, code(7), 10'h000},
        '{10'h27E, code(6), code(7)}, '{10'h080, HALF_SCALE_CODE, 10'h000}};
    always #50 ref_clk = ~ref_clk;
    adc_parallel_host_port i_dut (.ref_clk, .sys_rst, .chip_sel_n(cs_n),
        .write_n(wr_n), .read_n(rd_n), .host_data_bus_in(bus),
        .host_data_bus_out(dout), .host_data_bus_oe(oe), .analog_codes,
        .comparator_in(1'b0), .channel_sel(chan), .sample_hold(hold),
        .power_down(pd), .busy_int_n);
    host_model i_host (.ref_clk, .dev_out(dout), .dev_oe(oe), .cs_n,
        .wr_n, .rd_n, .bus);
    task automatic chk(input string nm, input logic [9:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wait_lvl(input logic lvl);
        for (int n = 0; n < 80 && busy_int_n !== lvl; n++)
            @(posedge ref_clk);
        chk("status", 10'(busy_int_n), 10'(lvl));
    endtask
    task automatic run_row(input row_s r);
        logic [9:0] v;
        @(posedge ref_clk);
        i_host.wr(r.ctrl, 1'b0);
        if (!r.ctrl[FLAG_MODE_POS])
            chk("busy", 10'(busy_int_n), 10'h000);
        if (r.ctrl[DUAL_SAMPLE_POS] && !r.ctrl[FLAG_MODE_POS]) begin
            repeat (16) @(posedge ref_clk);
            chk("dual busy", 10'(busy_int_n), 10'h000);
            chk("second channel", 10'(chan),
                10'(r.ctrl[SECOND_CHAN_LSB +: CHAN_W]));
            chk("hold active", 10'(hold), 10'h001);
        end
        wait_lvl(!r.ctrl[FLAG_MODE_POS]);
        repeat (8) @(posedge ref_clk);
        chk("hold idle", 10'(hold), 10'h000);
        chk("channel", 10'(chan), 10'(r.ctrl[DUAL_SAMPLE_POS]
            ? r.ctrl[SECOND_CHAN_LSB +: CHAN_W]
            : r.ctrl[FIRST_CHAN_LSB +: CHAN_W]));
        chk("power down", 10'(pd), 10'(r.ctrl[POWER_DOWN_POS]));
        i_host.rd(v);
        chk("first result", v, r.e1);
        if (r.ctrl[FLAG_MODE_POS])
            chk("flag clear", 10'(busy_int_n), 10'h001);
        if (r.ctrl[DUAL_SAMPLE_POS]) begin
            i_host.rd(v);
            chk("second result", v, r.e2);
        end
    endtask
    initial begin
        for (int k = 0; k < NUM_CHAN; k++)
            analog_codes[k*DATA_W+:DATA_W] = code(k);
        repeat (2) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        foreach (rows[i])
            run_row(rows[i]);
        @(posedge ref_clk);
        i_host.wr(10'h100, 1'b1);
        chk("ignored write", 10'(pd), 10'h000);
        chk("ignored start", 10'(busy_int_n), 10'h001);
        @(posedge ref_clk);
        i_host.wr(10'h100, 1'b0);
        chk("power down set", 10'(pd), 10'h001);
        #1 sys_rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        chk("reset control", 10'(pd), 10'h000);
        chk("reset status", 10'(busy_int_n), 10'h001);
        #1 sys_rst = 1'b0;
        tally_and_finish;
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        error_cnt++;
        tally_and_finish;
    end
endmodule
`default_nettype wire

/* File: src/adc_parallel_host_port.sv */
`timescale 1ns/1ns
`default_nettype none
module adc_parallel_host_port
    import adc_port_pkg::*;
#(
    parameter int DW = DATA_W
) (
    input  wire logic                 ref_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 chip_sel_n,
    input  wire logic                 write_n,
    input  wire logic                 read_n,
    input  wire logic [adc_port_pkg::DATA_W-1:0] host_data_bus_in,
    output logic [adc_port_pkg::DATA_W-1:0] host_data_bus_out,
    output logic                      host_data_bus_oe,
    input  wire logic [adc_port_pkg::NUM_CHAN*adc_port_pkg::DATA_W-1:0]
                                      analog_codes,
    input  wire logic                 comparator_in,
    output logic [adc_port_pkg::CHAN_W-1:0] channel_sel,
    output logic                      sample_hold,
    output logic                      power_down,
    output logic                      busy_int_n
);
    import adc_port_pkg::*;

    typedef enum logic [2:0] {IDLE, ACQ, SETTLE, CONV, DONE} conv_state_e;

    // Three-stage synchronisers for the strobe inputs, two stages for the data bus
    logic [2:0] cs_s_q, wr_s_q, rd_s_q;
    logic [DW-1:0] db_s1_q, db_s2_q;
    logic cs_n, wr_n, rd_n, wr_n_prev_q, rd_n_prev_q;
    logic cs_n_prev_q;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cs_s_q <= 3'h7;
            wr_s_q <= 3'h7;
            rd_s_q <= 3'h7;
            db_s1_q <= '0;
            db_s2_q <= '0;
        end else begin
            cs_s_q <= {cs_s_q[1:0], chip_sel_n};
            wr_s_q <= {wr_s_q[1:0], write_n};
            rd_s_q <= {rd_s_q[1:0], read_n};
            db_s1_q <= host_data_bus_in;
            db_s2_q <= db_s1_q;
        end
    end

    // Filtered levels: change counts once stages two and three agree
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cs_n_prev_q <= 1'b1;
            wr_n_prev_q <= 1'b1;
            rd_n_prev_q <= 1'b1;
        end else begin
            cs_n_prev_q <= cs_n;
            wr_n_prev_q <= wr_n;
            rd_n_prev_q <= rd_n;
        end
    end

    assign cs_n = (cs_s_q[1] == cs_s_q[2]) ? cs_s_q[2] : cs_n_prev_q;
    assign wr_n = (wr_s_q[1] == wr_s_q[2]) ? wr_s_q[2] : wr_n_prev_q;
    assign rd_n = (rd_s_q[1] == rd_s_q[2]) ? rd_s_q[2] : rd_n_prev_q;

    logic selected;
    logic wr_rise, wr_fall, rd_fall;
    assign selected = !cs_n;
    assign wr_rise = selected && wr_n && !wr_n_prev_q;
    assign wr_fall = selected && !wr_n && wr_n_prev_q;
    assign rd_fall = selected && !rd_n && rd_n_prev_q;

    // Data held in the synchroniser one stage shorter than the strobe
    logic [DW-1:0] wr_data_q;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            wr_data_q <= '0;
        else if (!wr_n)
            wr_data_q <= db_s2_q;
    end

    // Control register, write only
    logic [DW-1:0] ctrl_q;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            ctrl_q <= CTRL_RESET;
        else if (wr_rise)
            ctrl_q <= wr_data_q;
    end

    logic dual_sel, flag_mode;
    assign dual_sel = ctrl_q[DUAL_SAMPLE_POS];
    assign flag_mode = ctrl_q[FLAG_MODE_POS];

    // Conversion sequencer
    conv_state_e state_q;
    logic [3:0] cnt_q;
    logic [3:0] bit_q;
    logic second_q;
    logic [DW-1:0] approximation_register;
    logic [DW-1:0] held_code_q;
    logic conv_end;
    logic [DW-1:0] trial;

    assign trial = approximation_register | (DW'(1) << bit_q);
    assign conv_end = (state_q == CONV) && (bit_q == 4'h0)
                      && (cnt_q == 4'h0);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= IDLE;
            cnt_q <= 4'h0;
            bit_q <= 4'h0;
            second_q <= 1'b0;
        end else if (wr_rise) begin
            state_q <= ACQ;
            cnt_q <= 4'(ACQ_CYCLES - 1);
            second_q <= 1'b0;
        end else begin
            case (state_q)
                IDLE: begin
                end
                ACQ: begin
                    if (cnt_q == 4'h0) begin
                        state_q <= SETTLE;
                        cnt_q <= 4'(SETTLE_CYCLES - 1);
                    end else
                        cnt_q <= cnt_q - 4'h1;
                end
                SETTLE: begin
                    if (cnt_q == 4'h0) begin
                        state_q <= CONV;
                        bit_q <= 4'(DW - 1);
                        cnt_q <= 4'(BIT_CYCLES - 1);
                    end else
                        cnt_q <= cnt_q - 4'h1;
                end
                CONV: begin
                    if (cnt_q != 4'h0)
                        cnt_q <= cnt_q - 4'h1;
                    else if (bit_q != 4'h0) begin
                        bit_q <= bit_q - 4'h1;
                        cnt_q <= 4'(BIT_CYCLES - 1);
                    end else if (dual_sel && !second_q) begin
                        second_q <= 1'b1;
                        state_q <= SETTLE;
                        cnt_q <= 4'(SETTLE_CYCLES - 1);
                    end else
                        state_q <= DONE;
                end
                DONE: state_q <= IDLE;
                default: state_q <= IDLE;
            endcase
        end
    end

    // Successive approximation against the held code or comparator
    logic [DW-1:0] held_second_q;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            approximation_register <= '0;
            held_code_q <= '0;
            held_second_q <= '0;
        end else if (state_q == ACQ && cnt_q == 4'h0) begin
            held_code_q <= ctrl_q[HALF_SCALE_POS] ? HALF_SCALE_CODE :
                analog_codes[ctrl_q[FIRST_CHAN_LSB +: CHAN_W]*DW +: DW];
            held_second_q <= ctrl_q[HALF_SCALE_POS] ? HALF_SCALE_CODE :
                analog_codes[ctrl_q[SECOND_CHAN_LSB +: CHAN_W]*DW +: DW];
            approximation_register <= '0;
        end else if (state_q == SETTLE)
            approximation_register <= '0;
        else if (state_q == CONV && cnt_q == 4'h0) begin
            if ((second_q ? held_second_q : held_code_q) >= trial
                || comparator_in)
                approximation_register <= trial;
        end
    end

    // Result registers
    logic [DW-1:0] first_result_reg, second_result_reg;
    logic [DW-1:0] final_code;
    assign final_code = ((second_q ? held_second_q : held_code_q) >= trial
                         || comparator_in) ? trial : approximation_register;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            first_result_reg <= RESULT_RESET;
            second_result_reg <= RESULT_RESET;
        end else if (conv_end) begin
            if (second_q)
                second_result_reg <= final_code;
            else
                first_result_reg <= final_code;
        end
    end

    // Read toggles between the two result registers in dual mode
    logic rd_sel_q;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            rd_sel_q <= 1'b0;
        else if (wr_rise)
            rd_sel_q <= 1'b0;
        else if (!cs_n_prev_q && rd_n && !rd_n_prev_q && dual_sel)
            rd_sel_q <= !rd_sel_q;
    end

    // Data bus drive
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            host_data_bus_out <= '0;
            host_data_bus_oe <= 1'b0;
        end else begin
            host_data_bus_oe <= selected && !rd_n;
            host_data_bus_out <= rd_sel_q ? second_result_reg
                                          : first_result_reg;
        end
    end

    // Status flag
    logic busy_q, int_q;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            busy_q <= 1'b0;
        else if (wr_rise)
            busy_q <= 1'b1;
        else if (state_q == DONE)
            busy_q <= 1'b0;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            int_q <= 1'b0;
        else if (state_q == DONE)
            int_q <= 1'b1;
        else if (wr_fall || rd_fall)
            int_q <= 1'b0;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_int_n <= 1'b1;
            channel_sel <= '0;
            sample_hold <= 1'b0;
            power_down <= 1'b0;
        end else begin
            busy_int_n <= flag_mode ? !int_q : !busy_q;
            channel_sel <= second_q ? ctrl_q[SECOND_CHAN_LSB +: CHAN_W]
                                    : ctrl_q[FIRST_CHAN_LSB +: CHAN_W];
            sample_hold <= (state_q == SETTLE) || (state_q == CONV);
            power_down <= ctrl_q[POWER_DOWN_POS];
        end
    end
endmodule
`default_nettype wire

/* File: src/adc_port_pkg.sv */
package adc_port_pkg;
    localparam int DATA_W          = 10;
    localparam int CHAN_W          = 3;
    localparam int NUM_CHAN        = 8;
    localparam int FIRST_CHAN_LSB  = 0;
    localparam int SECOND_CHAN_LSB = 3;
    localparam int DUAL_SAMPLE_POS = 6;
    localparam int HALF_SCALE_POS  = 7;
    localparam int POWER_DOWN_POS  = 8;
    localparam int FLAG_MODE_POS   = 9;
    localparam logic [9:0] CTRL_RESET = 10'h000;
    localparam logic [9:0] RESULT_RESET = 10'h000;
    localparam logic [9:0] HALF_SCALE_CODE = 10'h000;
    localparam int CLK_PERIOD_NS   = 100;
    localparam int ACQ_CYCLES      = 4;
    localparam int SETTLE_CYCLES   = 2;
    localparam int BIT_CYCLES      = 1;
endpackage
